// file: src/exec_pkg.sv
// Constants, register map and types shared by the return and rotate execution block.
package exec_pkg;

    // APB register offsets (byte addresses, one word each).
    localparam logic [7:0] OFF_INSTR    = 8'h00;
    localparam logic [7:0] OFF_WORK     = 8'h04;
    localparam logic [7:0] OFF_STATUS   = 8'h08;
    localparam logic [7:0] OFF_BANK     = 8'h0c;
    localparam logic [7:0] OFF_SH_WORK  = 8'h10;
    localparam logic [7:0] OFF_SH_STAT  = 8'h14;
    localparam logic [7:0] OFF_SH_BANK  = 8'h18;
    localparam logic [7:0] OFF_INTCTL   = 8'h1c;
    localparam logic [7:0] OFF_PC       = 8'h20;
    localparam logic [7:0] OFF_LATCH    = 8'h24;
    localparam logic [7:0] OFF_CONFIG   = 8'h28;
    localparam logic [7:0] OFF_INDEX    = 8'h2c;

    // Field positions.
    localparam int INSTR_BUSY = 16;
    localparam int INSTR_ERR  = 17;
    localparam int ST_C       = 0;
    localparam int ST_Z       = 2;
    localparam int ST_N       = 4;
    localparam int INT_HIGH   = 7;
    localparam int INT_LOW    = 6;
    localparam int CFG_EXT    = 0;
    localparam int OPB_SHADOW = 0;
    localparam int OPB_ACCESS = 8;
    localparam int OPB_DEST   = 9;

    // Opcode patterns and masks.
    localparam logic [15:0] OP_INT_RET  = 16'h0010;
    localparam logic [15:0] OP_RETURN   = 16'h0012;
    localparam logic [15:0] OP_RET_MASK = 16'hfffe;
    localparam logic [15:0] OP_LIT_RET  = 16'h0c00;
    localparam logic [15:0] OP_LIT_MASK = 16'hff00;
    localparam logic [15:0] OP_ROT      = 16'h3400;
    localparam logic [15:0] OP_ROT_MASK = 16'hfc00;

    // Access bank split and upper bank of the access window.
    localparam logic [7:0] ACCESS_LIMIT = 8'h5f;
    localparam logic [3:0] ACCESS_HI    = 4'hf;

    // Quarter phases of one instruction cycle.
    localparam logic [1:0] Q_DECODE = 2'h0;
    localparam logic [1:0] Q_READ   = 2'h1;
    localparam logic [1:0] Q_PROC   = 2'h2;
    localparam logic [1:0] Q_WRITE  = 2'h3;
    localparam int         QUARTERS = 4;

    // Values after reset.
    localparam logic [7:0]  RST_BYTE   = 8'h00;
    localparam logic [3:0]  RST_BANK   = 4'h0;
    localparam logic [15:0] RST_OPCODE = 16'h0000;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_EXEC1 = 2'b01,
        ST_EXEC2 = 2'b11
    } state_t;

    typedef enum logic [1:0] {
        K_INT_RET = 2'h0,
        K_RETURN  = 2'h1,
        K_LIT_RET = 2'h2,
        K_ROT    = 2'h3
    } kind_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0]  wdata;
        logic        rd;
        logic        we;
    } file_req_t;

endpackage : exec_pkg

// file: src/quarter_sequencer.sv
// Free-running four-quarter phase counter of the instruction cycle.
`timescale 1ns/1ps
module quarter_sequencer
    import exec_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    output logic [1:0] q,
    output logic       q_last
);

    if (QUARTERS != 4) begin : g_chk
        $error("quarter_sequencer serves exactly four quarters");
    end

    logic [1:0] q_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q_q <= Q_DECODE;
        end else begin
            q_q <= q_q + 2'h1;
        end
    end

    assign q      = q_q;
    assign q_last = (q_q == Q_WRITE);

endmodule : quarter_sequencer

// file: src/rotate_carry_alu.sv
// Rotate left through carry with the carry, negative and zero results.
`timescale 1ns/1ps
module rotate_carry_alu (
    input  wire logic [7:0] operand,
    input  wire logic       carry_in,
    output logic [7:0] result,
    output logic       carry_out,
    output logic       negative,
    output logic       zero
);

    // The old carry enters bit 0 and bit 7 leaves into the carry.
    assign result    = {operand[6:0], carry_in};
    assign carry_out = operand[7];
    assign negative  = result[7];
    assign zero      = (result == 8'h00);

endmodule : rotate_carry_alu

// file: src/return_and_rotate_exec.sv
// Decoder and executor for the three returns and the rotate through carry.
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
// Summary of operation
// RQ1 - Interrupt return opcode 0000 0000 0001 000s, two cycles, second one idle.
// RQ2 - Interrupt return pops the stack into the PC in quarter four of cycle one.
// RQ3 - Interrupt return sets the high or low global enable, no other status.
// RQ4 - Interrupt return with s set restores work, status and bank from shadows.
// RQ5 - Literal return 0000 1100 kkkk kkkk, two cycles, literal to work, pop in Q4.
// RQ6 - Literal return writes all eight literal bits and keeps every status flag.
// RQ7 - All returns leave the PC high and upper latches untouched.
// RQ8 - Plain return 0000 0000 0001 001s, two cycles, pops to PC, flags kept.
// RQ9 - Plain return with s set restores work, status and bank from shadows.
// RQ10 - Rotate 0011 01da: bit 7 to carry, carry to bit 0, one cycle, C N Z.
// RQ11 - Rotate destination bit 0 writes work, 1 writes back the file register.
// RQ12 - Rotate access bit 0 uses access bank, 1 uses the bank select register.
// RQ13 - Access bit 0 with extended set enabled indexes addresses up to 5Fh.
// RQ14 - After rotate, negative is result bit 7 and zero marks a zero result.
module return_and_rotate_exec
    import exec_pkg::*;
#(
    parameter int PC_W = 21
) (
    input  wire logic            MCLK,
    input  wire logic            RST_N,
    input  wire logic            PSEL,
    input  wire logic            PENABLE,
    input  wire logic            PWRITE,
    input  wire logic [7:0]      PADDR,
    input  wire logic [31:0]     PWDATA,
    output logic [31:0]          PRDATA,
    output logic                 PREADY,
    output logic                 PSLVERR,
    input  wire logic [PC_W-1:0] TOP_OF_STACK,
    output logic                 STACK_POP,
    output logic [PC_W-1:0]      PC,
    output file_req_t            FILE_REQ,
    input  wire logic [7:0]      FILE_RDATA
);

    if (PC_W < 2 || PC_W > 32) begin : g_chk
        $error("PC_W must lie between 2 and 32");
    end

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [1:0]      q;
    logic            q_last;
    state_t          state_q;
    kind_t           kind_q;
    kind_t           kind_d;
    logic            kind_ok;
    logic [15:0]     opcode_q;
    logic            pending_q;
    logic            err_q;
    logic [7:0]      w_q;
    logic [7:0]      status_q;
    logic [3:0]      bank_q;
    logic [7:0]      sh_work_q;
    logic [7:0]      sh_stat_q;
    logic [3:0]      sh_bank_q;
    logic            hi_en_q;
    logic            lo_en_q;
    logic [PC_W-1:0] pc_q;
    logic [7:0]      latch_hi_q;
    logic [7:0]      latch_up_q;
    logic            ext_en_q;
    logic [11:0]     index_q;
    logic [11:0]     addr_q;
    logic [11:0]     addr_d;
    logic [7:0]      operand_q;
    logic [7:0]      result_q;
    logic [7:0]      rot_result;
    logic            rot_carry;
    logic            rot_neg;
    logic            rot_zero;
    logic [31:0]     prdata_q;
    logic [31:0]     rdata_d;
    logic            mapped;
    logic            busy;
    logic            wr_ok;
    logic            start;
    logic            exec_q4;
    logic            is_rot;
    logic            restore;
    logic [7:0]      fld_f;

    quarter_sequencer u_quarter (
        .clk    (MCLK),
        .rst_n  (RST_N),
        .q      (q),
        .q_last (q_last)
    );

    rotate_carry_alu u_rot (
        .operand   (operand_q),
        .carry_in  (status_q[ST_C]),
        .result    (rot_result),
        .carry_out (rot_carry),
        .negative  (rot_neg),
        .zero      (rot_zero)
    );

    // ************************************************************
    // APB slave
    // ************************************************************
    // Read data is captured in the setup cycle so PRDATA comes from a
    // flip-flop while the slave still answers with no wait state.
    always_comb begin
        mapped  = 1'b1;
        rdata_d = 32'h0;
        unique case (PADDR)
            OFF_INSTR:   rdata_d = {14'h0, err_q, busy, opcode_q};
            OFF_WORK:    rdata_d = {24'h0, w_q};
            OFF_STATUS:  rdata_d = {24'h0, status_q};
            OFF_BANK:    rdata_d = {28'h0, bank_q};
            OFF_SH_WORK: rdata_d = {24'h0, sh_work_q};
            OFF_SH_STAT: rdata_d = {24'h0, sh_stat_q};
            OFF_SH_BANK: rdata_d = {28'h0, sh_bank_q};
            OFF_INTCTL:  rdata_d = {24'h0, hi_en_q, lo_en_q, 6'h0};
            OFF_PC:      rdata_d = 32'(pc_q);
            OFF_LATCH:   rdata_d = {16'h0, latch_up_q, latch_hi_q};
            OFF_CONFIG:  rdata_d = {31'h0, ext_en_q};
            OFF_INDEX:   rdata_d = {20'h0, index_q};
            default:     mapped  = 1'b0;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            prdata_q <= 32'h0;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            prdata_q <= rdata_d;
        end
    end

    // Writes are refused while an instruction runs, so software never
    // races the core on the registers the instruction itself updates.
    assign busy    = pending_q || (state_q != ST_IDLE);
    assign wr_ok   = PSEL && PENABLE && PWRITE && mapped && !busy;
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL && PENABLE && (!mapped || (PWRITE && busy));
    assign PRDATA  = prdata_q;

    // ************************************************************
    // Decode and sequencing
    // ************************************************************
    always_comb begin
        kind_ok = 1'b1;
        kind_d  = K_INT_RET;
        if ((opcode_q & OP_RET_MASK) == OP_INT_RET) begin
            kind_d = K_INT_RET;                                   // RQ1
        end else if ((opcode_q & OP_RET_MASK) == OP_RETURN) begin
            kind_d = K_RETURN;                                    // RQ8
        end else if ((opcode_q & OP_LIT_MASK) == OP_LIT_RET) begin
            kind_d = K_LIT_RET;                                   // RQ5
        end else if ((opcode_q & OP_ROT_MASK) == OP_ROT) begin
            kind_d = K_ROT;                                       // RQ10
        end else begin
            kind_ok = 1'b0;
        end
    end

    assign start   = pending_q && q_last && (state_q == ST_IDLE);
    assign exec_q4 = (state_q == ST_EXEC1) && q_last;
    assign is_rot  = (kind_q == K_ROT);
    assign restore = exec_q4 && opcode_q[OPB_SHADOW]
                     && (kind_q == K_INT_RET || kind_q == K_RETURN);  // RQ4 RQ9

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            opcode_q  <= RST_OPCODE;
            pending_q <= 1'b0;
            err_q     <= 1'b0;
            kind_q    <= K_INT_RET;
        end else if (wr_ok && PADDR == OFF_INSTR) begin
            opcode_q  <= PWDATA[15:0];
            pending_q <= 1'b1;
            err_q     <= 1'b0;
        end else if (start) begin
            pending_q <= 1'b0;
            err_q     <= !kind_ok;
            kind_q    <= kind_d;
        end
    end

    // Returns spend a whole second cycle idle; the rotate ends after one.
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            state_q <= ST_IDLE;
        end else if (q_last) begin
            unique case (state_q)
                ST_IDLE:  state_q <= (start && kind_ok) ? ST_EXEC1 : ST_IDLE;
                ST_EXEC1: state_q <= is_rot ? ST_IDLE : ST_EXEC2;       // RQ1 RQ5 RQ8 RQ10
                ST_EXEC2: state_q <= ST_IDLE;
                default:  state_q <= ST_IDLE;
            endcase
        end
    end

    // ************************************************************
    // Program counter and stack
    // ************************************************************
    assign STACK_POP = exec_q4 && !is_rot;                              // RQ2 RQ5 RQ8

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            pc_q <= '0;
        end else if (STACK_POP) begin
            pc_q <= TOP_OF_STACK;                                       // RQ2 RQ5 RQ8
        end else if (wr_ok && PADDR == OFF_PC) begin
            pc_q <= PWDATA[PC_W-1:0];
        end
    end

    // The latches change only from software; no return touches them.
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            latch_hi_q <= RST_BYTE;
            latch_up_q <= RST_BYTE;
        end else if (wr_ok && PADDR == OFF_LATCH) begin                 // RQ7
            latch_hi_q <= PWDATA[7:0];
            latch_up_q <= PWDATA[15:8];
        end
    end

    assign PC = pc_q;

    // ************************************************************
    // Interrupt enables
    // ************************************************************
    // The high enable is set first; only when it is already set does the
    // return set the low enable instead.
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            hi_en_q <= 1'b0;
            lo_en_q <= 1'b0;
        end else if (exec_q4 && kind_q == K_INT_RET) begin
            if (!hi_en_q) begin
                hi_en_q <= 1'b1;                                        // RQ3
            end else begin
                lo_en_q <= 1'b1;                                        // RQ3
            end
        end else if (wr_ok && PADDR == OFF_INTCTL) begin
            hi_en_q <= PWDATA[INT_HIGH];
            lo_en_q <= PWDATA[INT_LOW];
        end
    end

    // ************************************************************
    // Core registers and shadows
    // ************************************************************
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            w_q <= RST_BYTE;
        end else if (restore) begin
            w_q <= sh_work_q;                                           // RQ4 RQ9
        end else if (exec_q4 && kind_q == K_LIT_RET) begin
            w_q <= opcode_q[7:0];                                       // RQ5 RQ6
        end else if (exec_q4 && is_rot && !opcode_q[OPB_DEST]) begin
            w_q <= result_q;                                            // RQ11
        end else if (wr_ok && PADDR == OFF_WORK) begin
            w_q <= PWDATA[7:0];
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            status_q <= RST_BYTE;
        end else if (restore) begin
            status_q <= sh_stat_q;                                      // RQ4 RQ9
        end else if (exec_q4 && is_rot) begin
            status_q[ST_C] <= rot_carry;                                // RQ10
            status_q[ST_N] <= rot_neg;                                  // RQ14
            status_q[ST_Z] <= rot_zero;                                 // RQ14
        end else if (wr_ok && PADDR == OFF_STATUS) begin
            status_q <= PWDATA[7:0];
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            bank_q <= RST_BANK;
        end else if (restore) begin
            bank_q <= sh_bank_q;                                        // RQ4 RQ9
        end else if (wr_ok && PADDR == OFF_BANK) begin
            bank_q <= PWDATA[3:0];
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            sh_work_q <= RST_BYTE;
            sh_stat_q <= RST_BYTE;
            sh_bank_q <= RST_BANK;
            ext_en_q  <= 1'b0;
            index_q   <= 12'h000;
        end else if (wr_ok) begin
            if (PADDR == OFF_SH_WORK) sh_work_q <= PWDATA[7:0];
            if (PADDR == OFF_SH_STAT) sh_stat_q <= PWDATA[7:0];
            if (PADDR == OFF_SH_BANK) sh_bank_q <= PWDATA[3:0];
            if (PADDR == OFF_CONFIG) ext_en_q <= PWDATA[CFG_EXT];
            if (PADDR == OFF_INDEX) index_q <= PWDATA[11:0];
        end
    end

    // ************************************************************
    // Rotate datapath
    // ************************************************************
    assign fld_f = opcode_q[7:0];

    always_comb begin
        if (opcode_q[OPB_ACCESS]) begin
            addr_d = {bank_q, fld_f};                                   // RQ12
        end else if (ext_en_q && fld_f <= ACCESS_LIMIT) begin
            addr_d = index_q + {4'h0, fld_f};                           // RQ13
        end else if (fld_f <= ACCESS_LIMIT) begin
            addr_d = {4'h0, fld_f};                                     // RQ12
        end else begin
            addr_d = {ACCESS_HI, fld_f};                                // RQ12
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            addr_q    <= 12'h000;
            operand_q <= RST_BYTE;
            result_q  <= RST_BYTE;
        end else if (state_q == ST_EXEC1 && is_rot) begin
            if (q == Q_DECODE) addr_q <= addr_d;
            if (q == Q_READ) operand_q <= FILE_RDATA;
            if (q == Q_PROC) result_q <= rot_result;                    // RQ10
        end
    end

    assign FILE_REQ.addr  = addr_q;
    assign FILE_REQ.wdata = result_q;
    assign FILE_REQ.rd    = (state_q == ST_EXEC1) && is_rot && (q == Q_READ);
    assign FILE_REQ.we    = exec_q4 && is_rot && opcode_q[OPB_DEST];    // RQ11

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    sequence s_ret_q4;
        exec_q4 && !is_rot;
    endsequence

    sequence s_rot_q4;
        exec_q4 && is_rot;
    endsequence

    sequence s_idle_cycle;
        (state_q == ST_EXEC2 && !STACK_POP && !FILE_REQ.we)[*4];
    endsequence

    ret_two_cycle_a: // RQ1
        assert property (s_ret_q4 |=> s_idle_cycle ##1 state_q == ST_IDLE)
        else $error("return did not spend one idle second cycle");

    ret_pc_load_a: // RQ2
        assert property (s_ret_q4 |-> STACK_POP ##1 pc_q == $past(TOP_OF_STACK))
        else $error("return did not load the popped stack value");

    int_enable_a: // RQ3
        assert property (exec_q4 && kind_q == K_INT_RET && !opcode_q[OPB_SHADOW]
                         |=> ((hi_en_q && $past(lo_en_q) == lo_en_q) || lo_en_q)
                             && status_q == $past(status_q))
        else $error("interrupt return enables or status wrong");

    shadow_restore_a: // RQ4
        assert property (restore |=> w_q == $past(sh_work_q) && status_q == $past(sh_stat_q)
                                     && bank_q == $past(sh_bank_q))
        else $error("shadow restore did not reach the core registers");

    no_restore_a: // RQ8
        assert property (s_ret_q4 ##0 (kind_q != K_LIT_RET && !opcode_q[OPB_SHADOW])
                         |=> $stable(w_q) && $stable(bank_q) && $stable(status_q[ST_Z]))
        else $error("return without shadow flag changed core registers");

    lit_load_a: // RQ6
        assert property (s_ret_q4 ##0 kind_q == K_LIT_RET
                         |=> w_q == $past(opcode_q[7:0]) && $stable(status_q))
        else $error("literal return wrote wrong work value or flags");

    latch_keep_a: // RQ7
        assert property (s_ret_q4 |=> $stable(latch_hi_q) && $stable(latch_up_q))
        else $error("return changed a PC latch");

    rot_flags_a: // RQ14
        assert property (s_rot_q4 |=> status_q[ST_C] == $past(operand_q[7])
                         && status_q[ST_N] == $past(result_q[7])
                         && status_q[ST_Z] == ($past(result_q) == 8'h00))
        else $error("rotate flags wrong");

    rot_result_a: // RQ10
        assert property (s_rot_q4 |-> result_q == {operand_q[6:0], status_q[ST_C]}
                                      ##1 state_q == ST_IDLE)
        else $error("rotate result or length wrong");

    rot_dest_a: // RQ11
        assert property (s_rot_q4 |-> FILE_REQ.we == opcode_q[OPB_DEST]
                         ##1 (opcode_q[OPB_DEST] || w_q == $past(result_q)))
        else $error("rotate destination wrong");

    bank_addr_a: // RQ12
        assert property (FILE_REQ.rd && opcode_q[OPB_ACCESS]
                         |-> FILE_REQ.addr == {bank_q, fld_f})
        else $error("banked rotate address wrong");

    index_addr_a: // RQ13
        assert property (FILE_REQ.rd && !opcode_q[OPB_ACCESS] && ext_en_q
                         && fld_f <= ACCESS_LIMIT |-> FILE_REQ.addr == index_q + {4'h0, fld_f})
        else $error("indexed rotate address wrong");

endmodule : return_and_rotate_exec

// file: sim/return_and_rotate_exec_bench.sv
// Self-checking bench for the return and rotate execution block.
`timescale 1ns/1ps
module return_and_rotate_exec_bench;
    import exec_pkg::*;
    localparam int PW = 21;
    logic            MCLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, STACK_POP;
    logic [7:0]      PADDR, FILE_RDATA;
    logic [31:0]     PWDATA, PRDATA, rv;
    logic [PW-1:0]   TOP_OF_STACK, PC;
    file_req_t       FILE_REQ;
    logic            er;
    logic [11:0]     rd_addr, wr_addr;
    logic [7:0]      wr_data;
    int              bad_count, checks, pops, wr_cnt;

    return_and_rotate_exec #(.PC_W(PW)) uut (.MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .TOP_OF_STACK(TOP_OF_STACK),
        .STACK_POP(STACK_POP), .PC(PC), .FILE_REQ(FILE_REQ), .FILE_RDATA(FILE_RDATA));

    initial begin
        MCLK = 1'b0;
        forever #2.5 MCLK = ~MCLK;
    end

    // ****************************************
    // Far-side monitor: pops and file traffic
    // ****************************************
    always @(posedge MCLK) begin
        if (STACK_POP === 1'b1) pops <= pops + 1;
        if (FILE_REQ.rd === 1'b1) rd_addr <= FILE_REQ.addr;
        if (FILE_REQ.we === 1'b1) begin
            wr_cnt  <= wr_cnt + 1;
            wr_addr <= FILE_REQ.addr;
            wr_data <= FILE_REQ.wdata;
        end
    end

    task automatic final_report;
        $display("checks=%0d mismatches=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : final_report

    task automatic check(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : check

    // Entered just after a rising edge; one idle edge at the end keeps PSEL single-driven.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        n = 0;
        do begin
            @(posedge MCLK);
            n++;
        end while (PREADY !== 1'b1 && n < 50);
        rv = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge MCLK);
        if (n >= 50) begin
            bad_count++;
            final_report;
        end
    endtask : apb

    task automatic exec(input logic [15:0] op);
        int n;
        apb(1'b1, OFF_INSTR, {16'h0000, op});
        n = 0;
        do begin
            apb(1'b0, OFF_INSTR, 32'h0);
            n++;
        end while (rv[INSTR_BUSY] !== 1'b0 && n < 40);
        if (n >= 40) begin
            bad_count++;
            final_report;
        end
    endtask : exec

    task automatic expect_reg(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rv, e);
    endtask : expect_reg

    initial begin
        RST_N = 1'b0; PSEL = 1'b0; PENABLE = 1'b0; PWRITE = 1'b0; PADDR = 8'h00;
        PWDATA = 32'h0; TOP_OF_STACK = '0; FILE_RDATA = 8'h00; pops = 0; wr_cnt = 0;
        bad_count = 0; checks = 0;
        repeat (8) @(posedge MCLK);
        RST_N <= 1'b1;
        @(posedge MCLK);
        expect_reg(OFF_STATUS, 32'h0);
        apb(1'b0, 8'h30, 32'h0);
        check({31'h0, er}, 32'h1);
        apb(1'b1, OFF_WORK, 32'h11);
        apb(1'b1, OFF_SH_WORK, 32'h5a);
        apb(1'b1, OFF_SH_STAT, 32'h15);
        apb(1'b1, OFF_SH_BANK, 32'h7);
        apb(1'b1, OFF_LATCH, 32'h1234);
        TOP_OF_STACK <= 21'h1abcd;
        exec(16'h0010);
        expect_reg(OFF_PC, 32'h1abcd);
        check(32'(pops), 32'h1);
        expect_reg(OFF_INTCTL, 32'h80);
        expect_reg(OFF_WORK, 32'h11);
        expect_reg(OFF_LATCH, 32'h1234);
        exec(16'h0010);
        expect_reg(OFF_INTCTL, 32'hc0);
        TOP_OF_STACK <= 21'h00246;
        exec(16'h0011);
        expect_reg(OFF_STATUS, 32'h15);
        expect_reg(OFF_BANK, 32'h7);
        $display("interrupt return test done");
        apb(1'b1, OFF_WORK, 32'h33);
        apb(1'b1, OFF_STATUS, 32'h0);
        TOP_OF_STACK <= 21'h10000;
        exec(16'h0012);
        expect_reg(OFF_PC, 32'h10000);
        expect_reg(OFF_WORK, 32'h33);
        expect_reg(OFF_STATUS, 32'h0);
        exec(16'h0013);
        expect_reg(OFF_WORK, 32'h5a);
        expect_reg(OFF_INTCTL, 32'hc0);
        apb(1'b1, OFF_STATUS, 32'h1f);
        TOP_OF_STACK <= 21'h00800;
        exec(16'h0ca5);
        expect_reg(OFF_WORK, 32'ha5);
        expect_reg(OFF_STATUS, 32'h1f);
        expect_reg(OFF_PC, 32'h00800);
        expect_reg(OFF_LATCH, 32'h1234);
        check(32'(pops), 32'h6);
        $display("return tests done");
        // *******************************
        // Rotate through carry
        // *******************************
        apb(1'b1, OFF_STATUS, 32'h03);
        FILE_RDATA <= 8'h80;
        exec(16'h3420);
        expect_reg(OFF_WORK, 32'h01);
        expect_reg(OFF_STATUS, 32'h03);
        check({20'h0, rd_addr}, 32'h020);
        check(32'(wr_cnt), 32'h0);
        apb(1'b1, OFF_BANK, 32'h3);
        apb(1'b1, OFF_STATUS, 32'h0);
        FILE_RDATA <= 8'h40;
        exec(16'h3780);
        check({20'h0, wr_addr}, 32'h380);
        check({24'h0, wr_data}, 32'h80);
        expect_reg(OFF_STATUS, 32'h10);
        expect_reg(OFF_WORK, 32'h01);
        apb(1'b1, OFF_STATUS, 32'h0);
        FILE_RDATA <= 8'h80;
        exec(16'h3690);
        check({20'h0, wr_addr}, 32'hf90);
        check({24'h0, wr_data}, 32'h00);
        expect_reg(OFF_STATUS, 32'h05);
        apb(1'b1, OFF_CONFIG, 32'h1);
        apb(1'b1, OFF_INDEX, 32'h100);
        exec(16'h3410);
        check({20'h0, rd_addr}, 32'h110);
        expect_reg(OFF_WORK, 32'h01);
        $display("rotate tests done");
        apb(1'b1, OFF_INSTR, 32'h0012);
        apb(1'b1, OFF_WORK, 32'h77);
        check({31'h0, er}, 32'h1);
        // The accepted return is still running; this refused write only waits it out.
        exec(16'h0012);
        exec(16'hffff);
        check({31'h0, rv[INSTR_ERR]}, 32'h1);
        expect_reg(OFF_WORK, 32'h01);
        $display("refusal tests done");
        final_report;
    end
endmodule : return_and_rotate_exec_bench
